//--- inc/psdl_regs.svh
// Offsets, field positions, reset values and timing counts of the strap default loader.
// Assumes a 32-bit APB slave with word-aligned registers and 16-bit data in the low bits.
`ifndef PSDL_REGS_SVH
`define PSDL_REGS_SVH

`define PSDL_OFF_FC1 8'h00
`define PSDL_OFF_FC2 8'h04
`define PSDL_OFF_HWCFG 8'h08
`define PSDL_OFF_BASIC 8'h0c
`define PSDL_OFF_ADV 8'h10
`define PSDL_OFF_MODE 8'h14
`define PSDL_OFF_SPECIAL 8'h18
`define PSDL_OFF_P1ADV 8'h1c
`define PSDL_OFF_STRAPS 8'h20

`define PSDL_STRAP_W 8
`define PSDL_SB_P1_FC 0
`define PSDL_SB_P2_BP 1
`define PSDL_SB_P2_PAUSE 2
`define PSDL_SB_P2_AMDIX 3
`define PSDL_SB_P2_MMDIX 4
`define PSDL_SB_P2_AN 5
`define PSDL_SB_P2_SPD 6
`define PSDL_SB_P2_DPX 7
`define PSDL_STRAP_RST 8'hee

`define PSDL_FC1_SEL 0
`define PSDL_FC2_BP 0
`define PSDL_FC2_TX 1
`define PSDL_FC2_RX 2
`define PSDL_HW_AMDIX 0
`define PSDL_HW_MMDIX 1
`define PSDL_BC_DPX 8
`define PSDL_BC_AN 12
`define PSDL_BC_SPD 13
`define PSDL_AD_10HD 5
`define PSDL_AD_10FD 6
`define PSDL_AD_100HD 7
`define PSDL_AD_100FD 8
`define PSDL_AD_SYM 10
`define PSDL_AD_ASYM 11
`define PSDL_AD_SELECTOR 16'h0001
`define PSDL_MODE_LSB 5
`define PSDL_SC_MDIX_STATE 13
`define PSDL_SC_MDIX_EN 14
`define PSDL_SC_SRC 15

`define PSDL_WM_FC1 16'h0001
`define PSDL_WM_FC2 16'h0007
`define PSDL_WM_BASIC 16'h3100
`define PSDL_WM_ADV 16'h0de0
`define PSDL_WM_MODE 16'h00e0
`define PSDL_WM_SPECIAL 16'he000
`define PSDL_WM_P1ADV 16'h0c00

`define PSDL_RST_FC1 16'h0000
`define PSDL_RST_FC2 16'h0007
`define PSDL_RST_BASIC 16'h3100
`define PSDL_RST_ADV 16'h0de0
`define PSDL_RST_MODE 16'h00e0
`define PSDL_RST_SPECIAL 16'h0000
`define PSDL_RST_P1ADV 16'h0c00

`define PSDL_SETTLE_CYCLES 3'h4

`endif

//--- inc/psdl_pkg.sv
// Types shared by the strap default loader modules.
// Assumes psdl_regs.svh supplies the numeric constants.
package psdl_pkg;
  typedef enum logic [1:0] {
    PSDL_HOLD,
    PSDL_SETTLE,
    PSDL_LOAD,
    PSDL_DONE
  } psdl_load_e;
  typedef logic [15:0] psdl_word_t;
  typedef logic [7:0] psdl_straps_t;
endpackage

//--- inc/psdl_strap_if.sv
// Carries raw strap levels into the synchroniser and clean levels back out.
// Assumes one clock domain on the clean side.
`timescale 1ns/1ps
interface psdl_strap_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src_mp (output raw, input clean);
  modport sync_mp (input raw, output clean);
endinterface

//--- hw/psdl_sync.sv
// Two-flop synchroniser bank for strap pins.
// Assumes the raw levels are asynchronous to clk.
`timescale 1ns/1ps
module psdl_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  psdl_strap_if.sync_mp bus
);
  logic [W-1:0] meta_r;
  logic [W-1:0] clean_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      clean_r <= '0;
    end else begin
      meta_r <= bus.raw;
      clean_r <= meta_r;
    end
  end

  assign bus.clean = clean_r;
endmodule // psdl_sync

//--- hw/psdl_top.sv
// Strap default loader for the second copper port and the first port's flow-control select.
// Assumes an APB master on CLK and strap pins that are stable around reset release.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "psdl_regs.svh"
module psdl_top #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PORT1_FC_SELECT_DEFAULT_PIN,
  input wire logic PORT2_BACKPRESSURE_DEFAULT_PIN,
  input wire logic PORT2_PAUSE_ENABLE_DEFAULT_PIN,
  input wire logic PORT2_MDIX_DEFAULT_PIN,
  input wire logic PORT2_AUTONEG_DEFAULT_PIN,
  input wire logic PORT2_SPEED_DEFAULT_PIN,
  input wire logic PORT2_DUPLEX_DEFAULT_PIN,
  input wire logic LED_PIN_ONE_I,
  output logic LED_PIN_ONE_O,
  output logic LED_PIN_ONE_OE_N,
  input wire logic LED_ACTIVITY,
  output logic STRAPS_LOADED,
  output logic PORT1_FLOW_CTRL_SELECT,
  output logic PORT2_BACKPRESSURE_ENABLE,
  output logic PORT2_TX_PAUSE_ENABLE,
  output logic PORT2_RX_PAUSE_ENABLE,
  output logic NEGOTIATION_ENABLE_BIT,
  output logic SPEED_SELECT_LOW_BIT,
  output logic DUPLEX_MODE_BIT,
  output logic [2:0] PHY_MODE,
  output logic CROSSOVER_AUTO_EN,
  output logic CROSSOVER_MDIX
);
  import psdl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Strap synchronisation and one-time capture.

  psdl_strap_if #(.W(`PSDL_STRAP_W)) strap_bus ();

  assign strap_bus.raw = {PORT2_DUPLEX_DEFAULT_PIN, PORT2_SPEED_DEFAULT_PIN, PORT2_AUTONEG_DEFAULT_PIN,
                          PORT2_MDIX_DEFAULT_PIN, LED_PIN_ONE_I, PORT2_PAUSE_ENABLE_DEFAULT_PIN,
                          PORT2_BACKPRESSURE_DEFAULT_PIN, PORT1_FC_SELECT_DEFAULT_PIN};

  psdl_sync #(.W(`PSDL_STRAP_W)) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .bus(strap_bus)
  );

  psdl_load_e load_r;
  logic [2:0] settle_cnt_r;
  psdl_straps_t strap_r;
  logic load_now;
  logic ready_r;

  assign load_now = (load_r == PSDL_LOAD);

  // The settle wait lets the synchroniser fill with real pin levels before capture.
  // Ready trails the load by a cycle, so read data captured while waiting holds the defaults.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      load_r <= PSDL_HOLD;
      settle_cnt_r <= 3'h0;
      ready_r <= 1'b0;
    end else begin
      ready_r <= (load_r == PSDL_DONE);
      case (load_r)
        PSDL_HOLD: begin
          load_r <= PSDL_SETTLE;
          settle_cnt_r <= 3'h0;
        end
        PSDL_SETTLE: begin
          if (settle_cnt_r == `PSDL_SETTLE_CYCLES - 3'h1) begin
            load_r <= PSDL_LOAD;
          end
          settle_cnt_r <= settle_cnt_r + 3'h1;
        end
        PSDL_LOAD: begin
          load_r <= PSDL_DONE;
        end
        PSDL_DONE: begin
          load_r <= PSDL_DONE;
        end
        default: begin
          load_r <= PSDL_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_r <= `PSDL_STRAP_RST;
    end else if (load_r == PSDL_SETTLE && settle_cnt_r == `PSDL_SETTLE_CYCLES - 3'h1) begin
      strap_r <= strap_bus.clean;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Defaults derived from the captured straps.

  logic s_an;
  logic s_spd;
  logic s_dpx;
  psdl_word_t def_fc1;
  psdl_word_t def_fc2;
  psdl_word_t def_basic;
  psdl_word_t def_adv;
  psdl_word_t def_mode;
  psdl_word_t def_p1adv;

  assign s_an = strap_r[`PSDL_SB_P2_AN];
  assign s_spd = strap_r[`PSDL_SB_P2_SPD];
  assign s_dpx = strap_r[`PSDL_SB_P2_DPX];

  always_comb begin
    def_fc1 = 16'h0000;
    def_fc1[`PSDL_FC1_SEL] = strap_r[`PSDL_SB_P1_FC];
    def_fc2 = 16'h0000;
    def_fc2[`PSDL_FC2_BP] = strap_r[`PSDL_SB_P2_BP];
    def_fc2[`PSDL_FC2_TX] = strap_r[`PSDL_SB_P2_PAUSE];
    def_fc2[`PSDL_FC2_RX] = strap_r[`PSDL_SB_P2_PAUSE];
    def_basic = 16'h0000;
    def_basic[`PSDL_BC_AN] = s_an;
    def_basic[`PSDL_BC_SPD] = s_an | s_spd;
    def_basic[`PSDL_BC_DPX] = s_an | s_dpx;
    def_adv = 16'h0000;
    def_adv[`PSDL_AD_100FD] = s_an | (s_spd & s_dpx);
    def_adv[`PSDL_AD_100HD] = s_an | s_spd;
    def_adv[`PSDL_AD_10FD] = s_an | (~s_spd & s_dpx);
    def_adv[`PSDL_AD_10HD] = s_an | ~s_spd;
    def_adv[`PSDL_AD_SYM] = 1'b1;
    def_adv[`PSDL_AD_ASYM] = strap_r[`PSDL_SB_P2_PAUSE];
    def_mode = 16'h0000;
    def_mode[`PSDL_MODE_LSB +: 3] = {s_an, s_spd, s_dpx};
    // Manual flow control advertises no pause, automatic control advertises both.
    def_p1adv = 16'h0000;
    def_p1adv[`PSDL_AD_SYM] = ~strap_r[`PSDL_SB_P1_FC];
    def_p1adv[`PSDL_AD_ASYM] = ~strap_r[`PSDL_SB_P1_FC];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave decode.

  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_fc1;
  logic hit_fc2;
  logic hit_hw;
  logic hit_basic;
  logic hit_adv;
  logic hit_mode;
  logic hit_spec;
  logic hit_p1adv;
  logic hit_straps;
  logic hit_any;
  logic hit_ro;
  psdl_word_t lane_mask;
  psdl_word_t wdata;

  // Registers answer only once defaults are loaded, so no write can be lost to the load.
  assign PREADY = ready_r;
  assign setup_ph = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE && PREADY;
  assign hit_fc1 = (PADDR == ADDR_W'(`PSDL_OFF_FC1));
  assign hit_fc2 = (PADDR == ADDR_W'(`PSDL_OFF_FC2));
  assign hit_hw = (PADDR == ADDR_W'(`PSDL_OFF_HWCFG));
  assign hit_basic = (PADDR == ADDR_W'(`PSDL_OFF_BASIC));
  assign hit_adv = (PADDR == ADDR_W'(`PSDL_OFF_ADV));
  assign hit_mode = (PADDR == ADDR_W'(`PSDL_OFF_MODE));
  assign hit_spec = (PADDR == ADDR_W'(`PSDL_OFF_SPECIAL));
  assign hit_p1adv = (PADDR == ADDR_W'(`PSDL_OFF_P1ADV));
  assign hit_straps = (PADDR == ADDR_W'(`PSDL_OFF_STRAPS));
  assign hit_ro = hit_hw || hit_straps;
  assign hit_any = hit_fc1 || hit_fc2 || hit_basic || hit_adv || hit_mode || hit_spec || hit_p1adv || hit_ro;
  assign PSLVERR = access_ph && (!hit_any || (PWRITE && hit_ro));
  assign wr_en = access_ph && PWRITE && hit_any && !hit_ro;
  assign lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  assign wdata = PWDATA[15:0];

  function automatic psdl_word_t merge(input psdl_word_t old_v, input psdl_word_t wmask,
                                       input psdl_word_t lanes, input psdl_word_t data);
    psdl_word_t m;
    m = wmask & lanes;
    return (old_v & ~m) | (data & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register file: reset value, then strap defaults once (all but the special register), then software writes.

  psdl_word_t fc1_r;
  psdl_word_t fc2_r;
  psdl_word_t basic_r;
  psdl_word_t adv_r;
  psdl_word_t mode_r;
  psdl_word_t spec_r;
  psdl_word_t p1adv_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fc1_r <= `PSDL_RST_FC1;
      fc2_r <= `PSDL_RST_FC2;
    end else if (load_now) begin
      fc1_r <= def_fc1;
      fc2_r <= def_fc2;
    end else if (wr_en) begin
      if (hit_fc1) begin
        fc1_r <= merge(fc1_r, `PSDL_WM_FC1, lane_mask, wdata);
      end
      if (hit_fc2) begin
        fc2_r <= merge(fc2_r, `PSDL_WM_FC2, lane_mask, wdata);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      basic_r <= `PSDL_RST_BASIC;
      adv_r <= `PSDL_RST_ADV;
      mode_r <= `PSDL_RST_MODE;
    end else if (load_now) begin
      basic_r <= def_basic;
      adv_r <= def_adv;
      mode_r <= def_mode;
    end else if (wr_en) begin
      if (hit_basic) begin
        basic_r <= merge(basic_r, `PSDL_WM_BASIC, lane_mask, wdata);
      end
      if (hit_adv) begin
        adv_r <= merge(adv_r, `PSDL_WM_ADV, lane_mask, wdata);
      end
      if (hit_mode) begin
        mode_r <= merge(mode_r, `PSDL_WM_MODE, lane_mask, wdata);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spec_r <= `PSDL_RST_SPECIAL;
      p1adv_r <= `PSDL_RST_P1ADV;
    end else if (load_now) begin
      p1adv_r <= def_p1adv;
    end else if (wr_en) begin
      if (hit_spec) begin
        spec_r <= merge(spec_r, `PSDL_WM_SPECIAL, lane_mask, wdata);
      end
      if (hit_p1adv) begin
        p1adv_r <= merge(p1adv_r, `PSDL_WM_P1ADV, lane_mask, wdata);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured while the request waits so it is stable in the access phase.

  psdl_word_t hw_word;
  psdl_word_t rd_word;

  always_comb begin
    hw_word = 16'h0000;
    hw_word[`PSDL_HW_AMDIX] = strap_r[`PSDL_SB_P2_AMDIX];
    hw_word[`PSDL_HW_MMDIX] = strap_r[`PSDL_SB_P2_MMDIX];
    rd_word = 16'h0000;
    if (hit_fc1) begin
      rd_word = fc1_r;
    end else if (hit_fc2) begin
      rd_word = fc2_r;
    end else if (hit_hw) begin
      rd_word = hw_word;
    end else if (hit_basic) begin
      rd_word = basic_r;
    end else if (hit_adv) begin
      rd_word = adv_r | `PSDL_AD_SELECTOR;
    end else if (hit_mode) begin
      rd_word = mode_r;
    end else if (hit_spec) begin
      rd_word = spec_r;
    end else if (hit_p1adv) begin
      rd_word = p1adv_r;
    end else if (hit_straps) begin
      rd_word = {8'h00, strap_r};
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
    end else if (setup_ph || (PSEL && !PREADY)) begin
      PRDATA <= {16'h0000, rd_word};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossover selection: straps rule only while the source select bit is clear.

  logic xover_auto_nxt;
  logic xover_mdix_nxt;

  always_comb begin
    if (!spec_r[`PSDL_SC_SRC]) begin
      xover_auto_nxt = strap_r[`PSDL_SB_P2_AMDIX];
      xover_mdix_nxt = !strap_r[`PSDL_SB_P2_AMDIX] && strap_r[`PSDL_SB_P2_MMDIX];
    end else begin
      xover_auto_nxt = spec_r[`PSDL_SC_MDIX_EN];
      xover_mdix_nxt = !spec_r[`PSDL_SC_MDIX_EN] && spec_r[`PSDL_SC_MDIX_STATE];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CROSSOVER_AUTO_EN <= 1'b0;
      CROSSOVER_MDIX <= 1'b0;
    end else if (load_r == PSDL_DONE) begin
      CROSSOVER_AUTO_EN <= xover_auto_nxt;
      CROSSOVER_MDIX <= xover_mdix_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared LED pin: released while its strap level is read, driven afterwards.

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LED_PIN_ONE_O <= 1'b0;
      LED_PIN_ONE_OE_N <= 1'b1;
    end else if (load_r == PSDL_DONE) begin
      LED_PIN_ONE_O <= LED_ACTIVITY;
      LED_PIN_ONE_OE_N <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control outputs, straight from register bits.

  assign STRAPS_LOADED = PREADY;
  assign PORT1_FLOW_CTRL_SELECT = fc1_r[`PSDL_FC1_SEL];
  assign PORT2_BACKPRESSURE_ENABLE = fc2_r[`PSDL_FC2_BP];
  assign PORT2_TX_PAUSE_ENABLE = fc2_r[`PSDL_FC2_TX];
  assign PORT2_RX_PAUSE_ENABLE = fc2_r[`PSDL_FC2_RX];
  assign NEGOTIATION_ENABLE_BIT = basic_r[`PSDL_BC_AN];
  assign SPEED_SELECT_LOW_BIT = basic_r[`PSDL_BC_SPD];
  assign DUPLEX_MODE_BIT = basic_r[`PSDL_BC_DPX];
  assign PHY_MODE = mode_r[`PSDL_MODE_LSB +: 3];

endmodule // psdl_top

//--- dv/psdl_chk.sv
// Concurrent checks on the top-level ports of the strap default loader.
// Assumes it is bound to psdl_top from the bench top file.
`timescale 1ns/1ps
module psdl_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic LED_ACTIVITY,
  input wire logic LED_PIN_ONE_O,
  input wire logic LED_PIN_ONE_OE_N,
  input wire logic STRAPS_LOADED,
  input wire logic [9:0] REG_BITS,
  input wire logic CROSSOVER_AUTO_EN,
  input wire logic CROSSOVER_MDIX
);
  logic wr_taken;
  assign wr_taken = PSEL && PENABLE && PWRITE && PREADY;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_settling; !STRAPS_LOADED [*5]; endsequence
  sequence s_access; PSEL && PENABLE && PREADY; endsequence
  property p_ready_tracks_load; PREADY == STRAPS_LOADED; endproperty
  a_ready_tracks_load: assert property (p_ready_tracks_load) else $error("PREADY differs from load state");
  property p_load_time; $rose(ARST_N) |-> s_settling ##[1:4] STRAPS_LOADED; endproperty
  a_load_time: assert property (p_load_time) else $error("strap load time out of range");
  property p_load_sticky; STRAPS_LOADED |=> STRAPS_LOADED; endproperty
  a_load_sticky: assert property (p_load_sticky) else $error("load state dropped");
  property p_led_released; !STRAPS_LOADED |-> LED_PIN_ONE_OE_N; endproperty
  a_led_released: assert property (p_led_released) else $error("LED pin driven while sampling");
  property p_led_follow;
    STRAPS_LOADED && $past(STRAPS_LOADED) |-> LED_PIN_ONE_O == $past(LED_ACTIVITY) && !LED_PIN_ONE_OE_N;
  endproperty
  a_led_follow: assert property (p_led_follow) else $error("LED pin does not follow activity");
  property p_xover_excl; CROSSOVER_AUTO_EN |-> !CROSSOVER_MDIX; endproperty
  a_xover_excl: assert property (p_xover_excl) else $error("manual MDIX with auto crossover on");
  property p_no_resample;
    STRAPS_LOADED && $past(STRAPS_LOADED) && !$past(wr_taken) |-> $stable(REG_BITS);
  endproperty
  a_no_resample: assert property (p_no_resample) else $error("register bit changed without write");
  property p_err_access; PSLVERR |-> PSEL && PENABLE; endproperty
  a_err_access: assert property (p_err_access) else $error("PSLVERR outside access phase");
  property p_unmapped; s_access ##0 (PADDR > 8'h20) |-> PSLVERR && PRDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_ro_write; s_access ##0 (PWRITE && (PADDR == 8'h08 || PADDR == 8'h20)) |-> PSLVERR; endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write not refused");
  property p_rdata_high; PRDATA[31:16] == 16'h0; endproperty
  a_rdata_high: assert property (p_rdata_high) else $error("upper read data not zero");
endmodule // psdl_chk

//--- dv/psdl_tb_top.sv
// Self-checking bench for the strap default loader.
// Assumes the bench drives straps, APB and LED activity; the checker is bound below.
`timescale 1ns/1ps
`include "psdl_regs.svh"
module psdl_tb_top;
  import psdl_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, err, led_act, led_i, led_o, led_oe_n, loaded;
  logic [7:0] paddr, straps;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, p1sel, bp_en, tx_en, rx_en, an_bit, spd_bit, dpx_bit, x_auto, x_mdix;
  logic [2:0] phy_mode;
  logic [11:0] outs;
  int n_errors, n_checks;
  logic [7:0] vecs [5] = '{8'h11, 8'h40, 8'h80, 8'h18, 8'hee};
  // The LED pin carries the auto crossover strap level until the design takes it over.
  assign led_i = led_oe_n ? straps[3] : led_o;
  assign outs = {p1sel, bp_en, tx_en, rx_en, an_bit, spd_bit, dpx_bit, phy_mode, x_auto, x_mdix};
  psdl_top dut (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT1_FC_SELECT_DEFAULT_PIN(straps[0]), .PORT2_BACKPRESSURE_DEFAULT_PIN(straps[1]),
    .PORT2_PAUSE_ENABLE_DEFAULT_PIN(straps[2]), .PORT2_MDIX_DEFAULT_PIN(straps[4]),
    .PORT2_AUTONEG_DEFAULT_PIN(straps[5]), .PORT2_SPEED_DEFAULT_PIN(straps[6]),
    .PORT2_DUPLEX_DEFAULT_PIN(straps[7]), .LED_PIN_ONE_I(led_i), .LED_PIN_ONE_O(led_o),
    .LED_PIN_ONE_OE_N(led_oe_n), .LED_ACTIVITY(led_act), .STRAPS_LOADED(loaded),
    .PORT1_FLOW_CTRL_SELECT(p1sel), .PORT2_BACKPRESSURE_ENABLE(bp_en), .PORT2_TX_PAUSE_ENABLE(tx_en),
    .PORT2_RX_PAUSE_ENABLE(rx_en), .NEGOTIATION_ENABLE_BIT(an_bit), .SPEED_SELECT_LOW_BIT(spd_bit),
    .DUPLEX_MODE_BIT(dpx_bit), .PHY_MODE(phy_mode), .CROSSOVER_AUTO_EN(x_auto), .CROSSOVER_MDIX(x_mdix)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) led_act <= ~led_act;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    if (n >= 400) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic e);
    apb(1'b1, a, d, st);
    check("pslverr", {31'h0, err}, {31'h0, e});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0, 4'h0);
    check($sformatf("reg %h", a), rd, x);
    check("pslverr", {31'h0, err}, {31'h0, e});
  endtask
  task automatic outc(input logic [11:0] x);
    repeat (2) @(negedge clk);
    check("outputs", {20'h0, outs}, {20'h0, x});
  endtask
  function automatic logic [31:0] exp_reg(input logic [7:0] v, input logic [7:0] a);
    logic p1, bp, pa, au, mx, an, sp, dx;
    {dx, sp, an, mx, au, pa, bp, p1} = v;
    case (a)
      8'h00: exp_reg = {31'h0, p1};
      8'h04: exp_reg = {29'h0, pa, pa, bp};
      8'h08: exp_reg = {30'h0, mx, au};
      8'h0c: exp_reg = {18'h0, an | sp, an, 3'h0, an | dx, 8'h0};
      8'h10: exp_reg = {20'h0, pa, 2'b10, an | (sp & dx), an | sp, an | (~sp & dx), an | ~sp, 5'h01};
      8'h14: exp_reg = {24'h0, an, sp, dx, 5'h0};
      8'h1c: exp_reg = {20'h0, ~p1, ~p1, 10'h0};
      8'h20: exp_reg = {24'h0, v};
      default: exp_reg = 32'h0;
    endcase
  endfunction
  function automatic logic [11:0] exp_outs(input logic [7:0] v);
    exp_outs = {v[0], v[1], v[2], v[2], v[5], v[5] | v[6], v[5] | v[7], v[5], v[6], v[7], v[3], ~v[3] & v[4]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Each strap set is loaded under a fresh reset; the first reads go out before loading ends.
  task automatic t_straps(input logic [7:0] v);
    @(posedge clk);
    arst_n <= 1'b0;
    straps <= v;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i <= 8; i++) begin
      rdc(8'(i * 4), exp_reg(v, 8'(i * 4)), 1'b0);
    end
    outc(exp_outs(v));
  endtask
  task automatic t_override();
    @(posedge clk);
    straps <= 8'h11;
    wrc(8'h04, 32'h0, 4'hf, 1'b0);
    wrc(8'h0c, 32'h0, 4'h1, 1'b0);
    rdc(8'h0c, 32'h3100, 1'b0);
    wrc(8'h0c, 32'h2000, 4'h3, 1'b0);
    wrc(8'h18, 32'ha000, 4'h3, 1'b0);
    rdc(8'h0c, 32'h2000, 1'b0);
    rdc(8'h20, 32'hee, 1'b0);
    rdc(8'h18, 32'ha000, 1'b0);
    outc(12'b0000_010_111_01);
    wrc(8'h18, 32'h0, 4'h3, 1'b0);
    outc(12'b0000_010_111_10);
  endtask
  task automatic t_errors();
    wrc(8'h08, 32'hffff, 4'hf, 1'b1);
    rdc(8'h08, 32'h1, 1'b0);
    wrc(8'h20, 32'h0, 4'hf, 1'b1);
    rdc(8'h20, 32'hee, 1'b0);
    rdc(8'h24, 32'h0, 1'b1);
  endtask
  initial begin
    n_errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    {psel, penable, pwrite, led_act} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    straps = 8'hee;
    foreach (vecs[i]) t_straps(vecs[i]);
    t_override();
    t_errors();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule // psdl_tb_top

bind psdl_top psdl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LED_ACTIVITY(LED_ACTIVITY),
  .LED_PIN_ONE_O(LED_PIN_ONE_O), .LED_PIN_ONE_OE_N(LED_PIN_ONE_OE_N), .STRAPS_LOADED(STRAPS_LOADED),
  .REG_BITS({PORT1_FLOW_CTRL_SELECT, PORT2_BACKPRESSURE_ENABLE, PORT2_TX_PAUSE_ENABLE, PORT2_RX_PAUSE_ENABLE,
    NEGOTIATION_ENABLE_BIT, SPEED_SELECT_LOW_BIT, DUPLEX_MODE_BIT, PHY_MODE}),
  .CROSSOVER_AUTO_EN(CROSSOVER_AUTO_EN), .CROSSOVER_MDIX(CROSSOVER_MDIX)
);
